// ---- logic/afe_consts.vh ----
`ifndef AFE_CONSTS_VH
`define AFE_CONSTS_VH
// --
// Class bytes
// --
`define AFE_CLA_STD 8'h00
`define AFE_CLA_WRAP 8'h90
// --
// Standard instructions
// --
`define AFE_INS_SELECT 8'hA4
`define AFE_INS_READ_BIN 8'hB0
`define AFE_INS_UPDATE_BIN 8'hD6
// --
// Wrapped native command codes
// --
`define AFE_NC_AUTH_FIRST 8'h71
`define AFE_NC_AUTH_NEXT 8'h77
`define AFE_NC_KEY_REPLACE 8'hC4
`define AFE_NC_TXN_CREATE 8'hCE
`define AFE_NC_TXN_DELETE 8'hDF
`define AFE_NC_VER_QUERY 8'h64
`define AFE_NC_FILE_FETCH 8'hAD
`define AFE_NC_FILE_STORE 8'h8D
`define AFE_NC_REC_FETCH 8'hAB
`define AFE_NC_REC_APPEND 8'h8B
`define AFE_NC_REC_MODIFY 8'hDB
// --
// Status trailers
// --
`define AFE_SW1_NATIVE 8'h91
`define AFE_RC_OK 8'h00
`define AFE_RC_LENGTH 8'h7E
`define AFE_RC_NO_KEY 8'h40
`define AFE_RC_DENIED 8'h9D
`define AFE_SW_LENGTH 16'h6700
`define AFE_SW_BAD_CLA 16'h6E00
`define AFE_SW_BAD_INS 16'h6D00
`define AFE_SW_NO_CHAIN 16'h6884
`define AFE_SW_NONE 16'h0000
// --
// Frame layout and counts
// --
`define AFE_POS_CLA 9'h000
`define AFE_POS_INS 9'h001
`define AFE_POS_P1 9'h002
`define AFE_POS_P2 9'h003
`define AFE_POS_B5 9'h004
`define AFE_DATA_START 9'h005
`define AFE_FRAME_MAX 9'h105
`define AFE_CNT_MAX 9'h1FF
`define AFE_ONE9 9'h001
`define AFE_ZERO9 9'h000
`define AFE_LE_ALL 9'h100
`define AFE_FSC_DEFAULT 9'h080
// --
// Key table
// --
`define AFE_KEY_APP_MAX 8'h04
`define AFE_GEN_MIN 8'h01
`define AFE_GEN_MAX 8'h04
`define AFE_SLOT_TXN 4'h5
`define AFE_SLOT_GEN_BASE 4'h5
`define AFE_KEY_SLOTS 10
`define AFE_VER_RESET 8'h00
`define AFE_CAP_LRP_BIT 1
`define AFE_AUTH_CAP_MIN_LC 8'h03
`define AFE_KEYNO_MIN_LC 8'h01
// --
// Command kinds
// --
`define AFE_KIND_NATIVE 2'h0
`define AFE_KIND_SELECT 2'h1
`define AFE_KIND_READ 2'h2
`define AFE_KIND_UPDATE 2'h3
`endif

// ---- logic/afe_tx_framer.v ----
`timescale 1ns/1ns
`include "afe_consts.vh"
// --
// Response block splitter
// --
module afe_tx_framer (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire in_valid_i,
   input wire [7:0] in_data_i,
   input wire in_final_i,
   output wire in_ready_o,
   input wire [8:0] fsd_i,
   output wire tx_valid_o,
   output wire [7:0] tx_data_o,
   output wire tx_end_o,
   output wire tx_more_o,
   input wire tx_ready_i
);
   reg valid_reg; // Output byte pending
   reg [7:0] data_reg; // Output byte
   reg end_reg; // Last byte of a block
   reg more_reg; // More response bytes follow
   reg [8:0] blk_cnt_reg; // Bytes already in current block
   wire [8:0] blk_next = blk_cnt_reg + `AFE_ONE9;
   // Block is full at the reader's announced size
   wire blk_full = (blk_next >= fsd_i);

   // New byte enters as the old one leaves
   assign in_ready_o = !valid_reg || tx_ready_i;
   assign tx_valid_o = valid_reg;
   assign tx_data_o = data_reg;
   assign tx_end_o = end_reg;
   assign tx_more_o = more_reg;

   // --
   // Output register and block counter
   // --
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         valid_reg <= 1'b0;
         data_reg <= 8'h00;
         end_reg <= 1'b0;
         more_reg <= 1'b0;
         blk_cnt_reg <= `AFE_ZERO9;
      end
      else if (in_valid_i && in_ready_o)
      begin
         // Only the final byte has nothing behind
         valid_reg <= 1'b1;
         data_reg <= in_data_i;
         end_reg <= in_final_i || blk_full;
         more_reg <= !in_final_i;
         blk_cnt_reg <= (in_final_i || blk_full) ? `AFE_ZERO9 : blk_next;
      end
      else if (tx_ready_i)
      begin
         // Byte taken, nothing new
         valid_reg <= 1'b0;
      end
   end
endmodule // afe_tx_framer

// ---- logic/afe_frame_front_end.v ----
`timescale 1ns/1ns
`include "afe_consts.vh"
// Functional notes
// - Transaction code key refused for authentication
// - Transaction file create/delete needs root authentication
// - Genuineness keys 1-4 only via LRP
// - Each key holds one version byte
// - Version set on replace/create, reported on query; replace writes application key slots only
// - Only APDU wrapped native commands execute
// - Native answer is return code plus data
// - Standard commands: select, read, update only
// - Native plain parameters least significant first
// - Crypto fields most significant first, untouched
// - Standard parameters most significant first
// - CLA, INS, P1, P2, Lc, data, Le
// - Le zero means all; native Le zero
// - Command data at most 255 bytes
// - Response data at most 256 bytes
// - Response ends with two status bytes
// - Chaining accepted only for listed commands
// - Long responses split to reader frame size
// - Header must fit first block, else length
// - Chained frame handled as one frame
// - Large writes start before frame completes
module afe_frame_front_end #(
   parameter [8:0] FSC_BYTES = `AFE_FSC_DEFAULT
) (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   input wire rx_end_i,
   input wire rx_chain_i,
   input wire [8:0] fsd_i,
   input wire card_level_i,
   input wire root_auth_i,
   input wire sm_lrp_i,
   output reg cmd_start_o,
   output reg [1:0] cmd_kind_o,
   output reg [7:0] cmd_ins_o,
   output reg [15:0] cmd_p1p2_o,
   output reg [15:0] cmd_arg16_o,
   output reg [7:0] cmd_lc_o,
   output reg [7:0] cmd_le_o,
   output reg cmd_early_o,
   output reg [8:0] rx_count_o,
   output reg rx_done_o,
   input wire [7:0] buf_addr_i,
   output reg [7:0] buf_data_o,
   input wire ver_wr_i,
   input wire [7:0] ver_val_i,
   output wire [7:0] txn_key_ver_o,
   input wire rsp_valid_i,
   input wire [7:0] rsp_data_i,
   output reg rsp_ready_o,
   input wire rsp_done_i,
   input wire [15:0] rsp_sw_i,
   output wire tx_valid_o,
   output wire [7:0] tx_data_o,
   output wire tx_end_o,
   output wire tx_more_o,
   input wire tx_ready_i
);
   // --
   // States, one-hot
   // --
   localparam [5:0] S_RX = 6'h01; // Collecting a frame
   localparam [5:0] S_CHK = 6'h02; // Judging a complete frame
   localparam [5:0] S_EXEC = 6'h04; // Back end running
   localparam [5:0] S_VER = 6'h08; // Own version answer
   localparam [5:0] S_SW1 = 6'h10; // First trailer byte
   localparam [5:0] S_SW2 = 6'h20; // Last trailer byte

   // --
   // Decode helpers
   // --
   // Commands allowed to span several blocks
   function chainable;
      input [7:0] cla;
      input [7:0] ins;
      begin
         chainable = (cla == `AFE_CLA_WRAP && (ins == `AFE_NC_FILE_FETCH ||
            ins == `AFE_NC_FILE_STORE || ins == `AFE_NC_REC_FETCH ||
            ins == `AFE_NC_REC_APPEND || ins == `AFE_NC_REC_MODIFY)) ||
            (cla == `AFE_CLA_STD && (ins == `AFE_INS_READ_BIN ||
            ins == `AFE_INS_UPDATE_BIN));
      end
   endfunction

   // Write commands that may outgrow the card buffer
   function big_write;
      input [7:0] cla;
      input [7:0] ins;
      begin
         big_write = (cla == `AFE_CLA_WRAP && (ins == `AFE_NC_FILE_STORE ||
            ins == `AFE_NC_REC_APPEND || ins == `AFE_NC_REC_MODIFY)) ||
            (cla == `AFE_CLA_STD && ins == `AFE_INS_UPDATE_BIN);
      end
   endfunction

   // Key number exists at the current level
   function key_ok;
      input card;
      input [7:0] key;
      begin
         key_ok = card ? (key >= `AFE_GEN_MIN && key <= `AFE_GEN_MAX) :
            (key <= `AFE_KEY_APP_MAX);
      end
   endfunction

   // Version slot of a key
   function [3:0] key_slot;
      input card;
      input [7:0] key;
      begin
         key_slot = card ? (`AFE_SLOT_GEN_BASE + key[3:0]) : key[3:0];
      end
   endfunction

   // --
   // Storage
   // --
   reg [5:0] state_reg; // Main state
   reg [8:0] rx_cnt_reg; // Bytes of reassembled frame
   reg [7:0] cla_reg; // Class byte
   reg [7:0] ins_reg; // Instruction
   reg [7:0] p1_reg; // First parameter
   reg [7:0] p2_reg; // Second parameter
   reg [7:0] b5_reg; // Lc, or Le if frame is five bytes
   reg [7:0] last_reg; // Most recent byte, Le candidate
   reg [7:0] d0_reg; // First data byte, key number
   reg [7:0] d1_reg; // Second data byte
   reg [7:0] d2_reg; // Third data byte, capability
   reg hdr_err_reg; // Block ended inside the header
   reg chain_err_reg; // Chaining on a non-chainable command
   reg [15:0] sw_reg; // Trailer to send
   reg [7:0] ver_out_reg; // Version byte to send
   reg [8:0] out_cnt_reg; // Response data bytes forwarded
   reg [8:0] le_cap_reg; // Response data ceiling
   reg [7:0] buf_mem [0:255]; // Reassembled data field
   reg [7:0] ver_mem [0:`AFE_KEY_SLOTS-1]; // Key versions
   integer i;

   wire fr_ready; // Framer can take a byte
   reg fr_valid; // Byte offered to framer
   reg [7:0] fr_data; // That byte
   reg fr_final; // It closes the response

   wire native = (cla_reg == `AFE_CLA_WRAP);
   wire std = (cla_reg == `AFE_CLA_STD);
   wire take = rx_valid_i && state_reg == S_RX;
   wire frame_end = take && rx_end_i && !rx_chain_i;
   wire [8:0] lc9 = {1'b0, b5_reg};
   wire in_data = rx_cnt_reg >= `AFE_DATA_START;
   wire [8:0] didx = rx_cnt_reg - `AFE_DATA_START;
   wire [8:0] dnext = didx + `AFE_ONE9;
   // Early start at card buffer size
   wire early = take && in_data && !cmd_early_o &&
      big_write(cla_reg, ins_reg) && dnext >= FSC_BYTES;
   wire room = out_cnt_reg < le_cap_reg;
   assign txn_key_ver_o = ver_mem[`AFE_SLOT_TXN];

   // --
   // Frame judgement
   // --
   reg le_only, with_le, no_le, len_ok, lrp_req, chk_err, chk_ver, is_auth;
   reg [7:0] le_val;
   reg [7:0] lc_val;
   reg [15:0] chk_sw;
   reg [15:0] len_sw;
   always @*
   begin
      // Five bytes: header plus Le
      le_only = (rx_cnt_reg == `AFE_DATA_START);
      with_le = (rx_cnt_reg == `AFE_DATA_START + lc9 + `AFE_ONE9);
      no_le = !le_only && (rx_cnt_reg == `AFE_DATA_START + lc9);
      len_ok = le_only || with_le || no_le;
      le_val = le_only ? b5_reg : (with_le ? last_reg : 8'h00);
      lc_val = le_only ? 8'h00 : b5_reg;
      is_auth = native && (ins_reg == `AFE_NC_AUTH_FIRST ||
         ins_reg == `AFE_NC_AUTH_NEXT);
      // LRP: capability bit, else session
      lrp_req = (ins_reg == `AFE_NC_AUTH_FIRST) ?
         (lc_val >= `AFE_AUTH_CAP_MIN_LC && d1_reg != 8'h00 &&
         d2_reg[`AFE_CAP_LRP_BIT]) : sm_lrp_i;
      len_sw = native ? {`AFE_SW1_NATIVE, `AFE_RC_LENGTH} : `AFE_SW_LENGTH;
      chk_err = 1'b1;
      chk_ver = 1'b0;
      chk_sw = `AFE_SW_NONE;
      if (hdr_err_reg)
         chk_sw = len_sw;
      else if (!native && !std)
         chk_sw = `AFE_SW_BAD_CLA;
      else if (!len_ok)
         chk_sw = len_sw;
      else if (chain_err_reg)
         chk_sw = `AFE_SW_NO_CHAIN;
      else if (std && ins_reg != `AFE_INS_SELECT &&
         ins_reg != `AFE_INS_READ_BIN && ins_reg != `AFE_INS_UPDATE_BIN)
         chk_sw = `AFE_SW_BAD_INS;
      else if (native && le_val != 8'h00)
         chk_sw = len_sw;
      else if ((is_auth || (native && ins_reg == `AFE_NC_VER_QUERY)) &&
         lc_val < `AFE_KEYNO_MIN_LC)
         chk_sw = len_sw;
      else if (is_auth && !key_ok(card_level_i, d0_reg))
         chk_sw = {`AFE_SW1_NATIVE, `AFE_RC_NO_KEY};
      else if (is_auth && card_level_i && !lrp_req)
         chk_sw = {`AFE_SW1_NATIVE, `AFE_RC_DENIED};
      else if (native && (ins_reg == `AFE_NC_TXN_CREATE ||
         ins_reg == `AFE_NC_TXN_DELETE) && !root_auth_i)
         chk_sw = {`AFE_SW1_NATIVE, `AFE_RC_DENIED};
      else if (native && ins_reg == `AFE_NC_VER_QUERY)
      begin
         // Answered here from the version table
         if (!key_ok(card_level_i, d0_reg))
            chk_sw = {`AFE_SW1_NATIVE, `AFE_RC_NO_KEY};
         else
         begin
            chk_err = 1'b0;
            chk_ver = 1'b1;
            chk_sw = {`AFE_SW1_NATIVE, `AFE_RC_OK};
         end
      end
      else
         chk_err = 1'b0;
   end

   // --
   // Byte source for the framer
   // --
   always @*
   begin
      fr_valid = 1'b0;
      fr_data = 8'h00;
      fr_final = 1'b0;
      rsp_ready_o = 1'b0;
      case (state_reg)
         S_EXEC:
         begin
            // Bytes past the ceiling are swallowed, not sent
            fr_valid = rsp_valid_i && room;
            fr_data = rsp_data_i;
            rsp_ready_o = fr_ready || !room;
         end
         S_VER:
         begin
            fr_valid = 1'b1;
            fr_data = ver_out_reg;
         end
         S_SW1:
         begin
            fr_valid = 1'b1;
            fr_data = sw_reg[15:8];
         end
         S_SW2:
         begin
            fr_valid = 1'b1;
            fr_data = sw_reg[7:0];
            fr_final = 1'b1;
         end
         default:
         begin
            fr_valid = 1'b0;
         end
      endcase
   end

   // --
   // Data field buffer, kept in arrival order
   // --
   // Crypto fields pass unreordered
   always @(posedge ref_clk_i)
   begin
      if (take && in_data && rx_cnt_reg < `AFE_FRAME_MAX)
         buf_mem[didx[7:0]] <= rx_data_i;
      buf_data_o <= buf_mem[buf_addr_i];
   end

   // --
   // Key version table
   // --
   // Only replace and create write versions
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         for (i = 0; i < `AFE_KEY_SLOTS; i = i + 1)
            ver_mem[i] <= `AFE_VER_RESET;
      end
      else if (ver_wr_i && state_reg == S_EXEC && native)
      begin
         if (ins_reg == `AFE_NC_TXN_CREATE)
            ver_mem[`AFE_SLOT_TXN] <= ver_val_i;
         else if (ins_reg == `AFE_NC_KEY_REPLACE && key_ok(1'b0, d0_reg))
            ver_mem[key_slot(1'b0, d0_reg)] <= ver_val_i;
      end
   end

   // --
   // Receive, judge and sequence
   // --
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_reg <= S_RX;
         rx_cnt_reg <= `AFE_ZERO9;
         cla_reg <= 8'h00;
         ins_reg <= 8'h00;
         p1_reg <= 8'h00;
         p2_reg <= 8'h00;
         b5_reg <= 8'h00;
         last_reg <= 8'h00;
         d0_reg <= 8'h00;
         d1_reg <= 8'h00;
         d2_reg <= 8'h00;
         hdr_err_reg <= 1'b0;
         chain_err_reg <= 1'b0;
         sw_reg <= `AFE_SW_NONE;
         ver_out_reg <= 8'h00;
         out_cnt_reg <= `AFE_ZERO9;
         le_cap_reg <= `AFE_LE_ALL;
         cmd_start_o <= 1'b0;
         cmd_kind_o <= `AFE_KIND_NATIVE;
         cmd_ins_o <= 8'h00;
         cmd_p1p2_o <= 16'h0000;
         cmd_arg16_o <= 16'h0000;
         cmd_lc_o <= 8'h00;
         cmd_le_o <= 8'h00;
         cmd_early_o <= 1'b0;
         rx_count_o <= `AFE_ZERO9;
         rx_done_o <= 1'b0;
      end
      else
      begin
         cmd_start_o <= 1'b0;
         // Shared by early and normal start
         if (early || (state_reg == S_CHK && !chk_err && !chk_ver &&
            !cmd_early_o))
         begin
            cmd_start_o <= 1'b1;
            cmd_kind_o <= native ? `AFE_KIND_NATIVE :
               (ins_reg == `AFE_INS_SELECT ? `AFE_KIND_SELECT :
               (ins_reg == `AFE_INS_READ_BIN ? `AFE_KIND_READ : `AFE_KIND_UPDATE));
            cmd_ins_o <= ins_reg;
            cmd_p1p2_o <= {p1_reg, p2_reg};
            // Native plain values arrive low byte first
            cmd_arg16_o <= native ? {d1_reg, d0_reg} : {d0_reg, d1_reg};
            cmd_lc_o <= early ? b5_reg : lc_val;
            cmd_le_o <= early ? 8'h00 : le_val;
         end
         if (early)
            cmd_early_o <= 1'b1;
         case (state_reg)
            S_RX:
            begin
               if (take)
               begin
                  // Whole chain is reassembled into one frame
                  if (rx_cnt_reg != `AFE_CNT_MAX)
                     rx_cnt_reg <= rx_cnt_reg + `AFE_ONE9;
                  last_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_POS_CLA)
                     cla_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_POS_INS)
                     ins_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_POS_P1)
                     p1_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_POS_P2)
                     p2_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_POS_B5)
                     b5_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_DATA_START)
                     d0_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_DATA_START + `AFE_ONE9)
                     d1_reg <= rx_data_i;
                  if (rx_cnt_reg == `AFE_DATA_START + `AFE_ONE9 + `AFE_ONE9)
                     d2_reg <= rx_data_i;
                  if (in_data && rx_cnt_reg < `AFE_FRAME_MAX)
                     rx_count_o <= dnext;
                  // Block closing mid-header
                  if (rx_end_i && rx_chain_i && rx_cnt_reg < `AFE_POS_P2)
                     hdr_err_reg <= 1'b1;
                  if (rx_end_i && rx_chain_i && rx_cnt_reg >= `AFE_POS_P2 &&
                     !chainable(cla_reg, ins_reg))
                     chain_err_reg <= 1'b1;
               end
               if (frame_end)
               begin
                  rx_done_o <= 1'b1;
                  state_reg <= S_CHK;
               end
            end
            S_CHK:
            begin
               out_cnt_reg <= `AFE_ZERO9;
               // Le zero asks for 256
               le_cap_reg <= (le_val == 8'h00) ? `AFE_LE_ALL : {1'b0, le_val};
               sw_reg <= chk_sw;
               ver_out_reg <= ver_mem[key_slot(card_level_i, d0_reg)];
               // Early write is committed
               if (cmd_early_o)
                  state_reg <= S_EXEC;
               else if (chk_err)
                  state_reg <= S_SW1;
               else if (chk_ver)
                  state_reg <= S_VER;
               else
                  state_reg <= S_EXEC;
            end
            S_EXEC:
            begin
               if (fr_valid && fr_ready)
                  out_cnt_reg <= out_cnt_reg + `AFE_ONE9;
               if (rsp_done_i)
               begin
                  // Native code in second status byte
                  sw_reg <= native ? {`AFE_SW1_NATIVE, rsp_sw_i[7:0]} : rsp_sw_i;
                  state_reg <= S_SW1;
               end
            end
            S_VER:
            begin
               if (fr_ready)
                  state_reg <= S_SW1;
            end
            S_SW1:
            begin
               if (fr_ready)
                  state_reg <= S_SW2;
            end
            S_SW2:
            begin
               if (fr_ready)
               begin
                  // Back to listening
                  state_reg <= S_RX;
                  rx_cnt_reg <= `AFE_ZERO9;
                  hdr_err_reg <= 1'b0;
                  chain_err_reg <= 1'b0;
                  cmd_early_o <= 1'b0;
                  rx_done_o <= 1'b0;
                  rx_count_o <= `AFE_ZERO9;
               end
            end
            default:
            begin
               state_reg <= S_RX;
            end
         endcase
      end
   end

   // --
   // Response block splitter
   // --
   afe_tx_framer u_framer (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(fr_valid),
      .in_data_i(fr_data),
      .in_final_i(fr_final),
      .in_ready_o(fr_ready),
      .fsd_i(fsd_i),
      .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o),
      .tx_end_o(tx_end_o),
      .tx_more_o(tx_more_o),
      .tx_ready_i(tx_ready_i)
   );
endmodule // afe_frame_front_end

// ---- logic/afe_pad.v ----
`timescale 1ns/1ns

// ---- sim/afe_chk_checker.sv ----
`timescale 1ns/1ns
`include "afe_consts.vh"
// --
// Port checker
// --
module afe_chk (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire [8:0] fsd_i,
   input wire tx_ready_i,
   input wire cmd_start_o,
   input wire [7:0] cmd_ins_o,
   input wire cmd_early_o,
   input wire [8:0] rx_count_o,
   input wire rx_done_o,
   input wire tx_valid_o,
   input wire [7:0] tx_data_o,
   input wire tx_end_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   reg [8:0] blk_reg; // Bytes sent in open block
   // Count bytes of the open answer block
   always @(posedge ref_clk_i or negedge resetn_i)
      if (!resetn_i)
         blk_reg <= 9'h000;
      else if (tx_valid_o && tx_ready_i)
         blk_reg <= tx_end_o ? 9'h000 : blk_reg + 9'h001;
   a_tx_held: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("tx dropped");
   a_block_cap: assert property (
      tx_valid_o && blk_reg == fsd_i - 9'h001 |-> tx_end_o) else $error("block too long");
   a_one_start: assert property (
      cmd_start_o |=> !cmd_start_o) else $error("start repeated");
   a_whole_frame: assert property (
      cmd_start_o && !cmd_early_o |-> $past(rx_done_o)) else $error("start before frame end");
   a_judge_soon: assert property (
      $rose(rx_done_o) && !cmd_early_o |-> ##[1:2] (cmd_start_o || tx_valid_o)) else $error("no verdict");
   a_early_write: assert property (
      cmd_start_o && cmd_early_o |-> cmd_ins_o inside {`AFE_NC_FILE_STORE, `AFE_NC_REC_APPEND,
      `AFE_NC_REC_MODIFY, `AFE_INS_UPDATE_BIN}) else $error("early start on non-write");
   a_early_mid: assert property (
      cmd_start_o && cmd_early_o |-> !rx_done_o) else $error("early start too late");
   a_cmd_len: assert property (
      rx_count_o <= 9'h100) else $error("command data too long");
   c_early: cover property (cmd_start_o && cmd_early_o);
   c_whole: cover property (cmd_start_o && !cmd_early_o);
   c_block: cover property (tx_valid_o && tx_ready_i && tx_end_o && blk_reg == 9'h001);
endmodule // afe_chk
bind afe_frame_front_end afe_chk chk (.ref_clk_i, .resetn_i, .fsd_i, .tx_ready_i, .cmd_start_o,
   .cmd_ins_o, .cmd_early_o, .rx_count_o, .rx_done_o, .tx_valid_o, .tx_data_o, .tx_end_o);

// ---- sim/afe_pcd_model.sv ----
`timescale 1ns/1ns
// --
// Reader model
// --
module afe_pcd_model (
   input wire ref_clk_i,
   output reg rx_valid_o,
   output reg [7:0] rx_data_o,
   output reg rx_end_o,
   output reg rx_chain_o,
   input wire tx_valid_i,
   input wire [7:0] tx_data_i,
   input wire tx_end_i,
   output reg tx_ready_o
);
   logic [7:0] got[$]; // Answer bytes taken
   int blocks = 0; // Answer blocks closed
   initial {rx_valid_o, rx_data_o, rx_end_o, rx_chain_o, tx_ready_o} = 12'h000;
   // Send frame; ch closes a block after P2
   task send(input [127:0] f, input int n, input bit ch);
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk_i) #1;
         rx_valid_o = 1'b1;
         rx_data_o = f[8*(n-1-i) +: 8];
         rx_chain_o = ch && i == 3;
         rx_end_o = i == n - 1 || rx_chain_o;
      end
      @(posedge ref_clk_i) #1;
      {rx_valid_o, rx_end_o, rx_chain_o} = 3'h0;
      rx_data_o = ~rx_data_o; // Released line must not look stable
   endtask
   // Half-rate sink stalls every other cycle
   always @(posedge ref_clk_i)
   begin
      if (tx_valid_i && tx_ready_o)
      begin
         got.push_back(tx_data_i);
         blocks <= blocks + tx_end_i;
      end
      tx_ready_o <= ~tx_ready_o;
   end
endmodule // afe_pcd_model

// ---- sim/apdu_frame_front_end_test.sv ----
`timescale 1ns/1ns
`include "afe_consts.vh"
module apdu_frame_front_end_test;
   reg ref_clk = 1'b0; // 50 MHz
   reg resetn = 1'b0; // Active low reset
   reg card_lvl = 1'b0; // Card level selected
   reg root_auth = 1'b0; // Root key authenticated
   reg rsp_valid = 1'b0; // Back end byte strobe
   reg [7:0] rsp_data = 8'h00; // Back end byte
   reg rsp_done = 1'b0; // Back end finished
   reg [15:0] rsp_sw = 16'h0000; // Back end status
   reg [15:0] sw; // Last status pair seen
   wire rx_valid, rx_end, rx_chain, tx_ready, cmd_start, cmd_early, rx_done, rsp_ready, tx_valid;
   wire tx_end;
   wire [7:0] rx_data, tx_data;
   wire [1:0] cmd_kind;
   wire [15:0] cmd_p1p2, cmd_arg16;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0; // Hang guard
   afe_pcd_model pcd (.ref_clk_i(ref_clk), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
      .rx_end_o(rx_end), .rx_chain_o(rx_chain), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
      .tx_end_i(tx_end), .tx_ready_o(tx_ready));
   afe_frame_front_end #(.FSC_BYTES(9'h008)) dut (.ref_clk_i(ref_clk), .resetn_i(resetn),
      .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_end_i(rx_end), .rx_chain_i(rx_chain),
      .fsd_i(9'h002), .card_level_i(card_lvl), .root_auth_i(root_auth), .sm_lrp_i(1'b0),
      .cmd_start_o(cmd_start), .cmd_kind_o(cmd_kind), .cmd_ins_o(), .cmd_p1p2_o(cmd_p1p2),
      .cmd_arg16_o(cmd_arg16), .cmd_lc_o(), .cmd_le_o(), .cmd_early_o(cmd_early),
      .rx_count_o(), .rx_done_o(rx_done), .buf_addr_i(rsp_data), .buf_data_o(), .ver_wr_i(1'b0),
      .ver_val_i(8'h00), .txn_key_ver_o(), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
      .rsp_ready_o(rsp_ready), .rsp_done_i(rsp_done), .rsp_sw_i(rsp_sw), .tx_valid_o(tx_valid),
      .tx_data_o(tx_data), .tx_end_o(tx_end), .tx_more_o(), .tx_ready_i(tx_ready));
   // --
   // Helpers
   // --
   task check(input [15:0] seen, input [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Wait for m bytes, keep last two
   task collect(input int m);
      for (int i = 0; i < 400 && pcd.got.size() < m; i++) @(posedge ref_clk) #1;
      sw = {pcd.got[m-2], pcd.got[m-1]};
   endtask
   task ask(input [127:0] f, input int n, input bit ch, input int m);
      pcd.got.delete();
      pcd.blocks = 0;
      fork
         pcd.send(f, n, ch);
      join_none
      if (m > 0)
         collect(m);
   endtask
   task wait_start;
      for (int i = 0; i < 400 && cmd_start !== 1'b1; i++) @(posedge ref_clk) #1;
   endtask
   // Valid stays up between bytes
   task feed(input [7:0] b);
      rsp_valid = 1'b1;
      rsp_data = b;
      for (int i = 0; i < 400 && rsp_ready !== 1'b1; i++) @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
   endtask
   task finish(input [15:0] s);
      rsp_valid = 1'b0;
      rsp_done = 1'b1;
      rsp_sw = s;
      @(posedge ref_clk) #1;
      rsp_done = 1'b0;
   endtask
   // --
   // Scenarios
   // --
   task t_refusals;
      ask(40'h80A4000000, 5, 0, 2);
      check(sw, `AFE_SW_BAD_CLA);
      ask(40'h00CA000000, 5, 0, 2);
      check(sw, `AFE_SW_BAD_INS);
      ask(40'h9064000005, 5, 0, 2);
      check(sw, 16'h917E);
      ask(24'h00B000, 3, 0, 2);
      check(sw, `AFE_SW_LENGTH);
      ask(56'h90710000010500, 7, 0, 2);
      check(sw, 16'h9140);
      ask(56'h90CE0000010F00, 7, 0, 2);
      check(sw, 16'h919D);
      root_auth = 1'b1;
      ask(56'h90CE0000010F00, 7, 0, 0);
      wait_start;
      finish(16'h0000);
      collect(2);
      check(sw, 16'h9100);
      root_auth = 1'b0;
      ask(64'h00A4000002E10400, 8, 1, 2);
      check(sw, `AFE_SW_NO_CHAIN);
      card_lvl = 1'b1;
      ask(56'h90710000010100, 7, 0, 2);
      check(sw, 16'h919D);
      card_lvl = 1'b0;
      $display("refusals done");
   endtask
   // Four bytes against Le 3, two-byte blocks
   task t_read;
      ask(40'h00B0001003, 5, 0, 0);
      wait_start;
      check(cmd_p1p2, 16'h0010);
      check({14'h0000, cmd_kind}, {14'h0000, `AFE_KIND_READ});
      for (int k = 0; k < 4; k++) feed(8'hA1 + k[7:0]);
      finish(16'h9000);
      collect(5);
      check(sw, 16'h9000);
      check({pcd.got[0], pcd.got[2]}, 16'hA1A3);
      check(pcd.blocks[15:0], 16'h0003);
      $display("read done");
   endtask
   task t_native;
      ask(72'h90AD00000301200000, 9, 0, 0);
      wait_start;
      check(cmd_arg16, 16'h2001);
      finish(16'h0000);
      collect(2);
      check(sw, 16'h9100);
      $display("native done");
   endtask
   task t_early;
      ask(120'h00D600000A1234565A5B5C5D5E5F60, 15, 1, 0);
      wait_start;
      check({14'h0000, cmd_early, rx_done}, 16'h0002);
      check(cmd_arg16, 16'h1234);
      for (int i = 0; i < 400 && rx_done !== 1'b1; i++) @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
      finish(16'h9000);
      collect(2);
      check(sw, 16'h9000);
      $display("early write done");
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always #10 ref_clk = ~ref_clk;
   // Cut a hang short
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         give_verdict;
      end
   end
   initial
   begin
      repeat (8) @(posedge ref_clk);
      #1 resetn = 1'b1;
      t_refusals;
      t_read;
      t_native;
      t_early;
      give_verdict;
   end
endmodule // apdu_frame_front_end_test
